// ===== design/pcd_defs.vh
// Register map, reset values and field positions of the pin change detector
`ifndef PCD_DEFS_VH
`define PCD_DEFS_VH

`define PCD_ADDR_W 4
`define PCD_OFS_RISE 4'h0
`define PCD_OFS_FALL 4'h4
`define PCD_OFS_FLAG 4'h8
`define PCD_OFS_CTRL 4'hC

`define PCD_RST_BYTE 8'h00
`define PCD_PINS 8

`define PCD_CTRL_IRQ_EN 0
`define PCD_CTRL_SUMMARY 1

`endif

// ===== design/pcd_pin_sync.v
// Two-stage pin synchroniser with edge detection per pin
`timescale 1ns/1ps
`include "pcd_defs.vh"

module pcd_pin_sync (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Pins
  input wire [7:0] pin_in,
  // Edges
  output wire [7:0] rise_seen,
  output wire [7:0] fall_seen
);

  reg [7:0] meta_q;
  reg [7:0] sync_q;
  reg [7:0] prev_q;
  reg [2:0] prime_q;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
      prev_q <= 8'h00;
      prime_q <= 3'b000;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
      prime_q <= {prime_q[1:0], 1'b1};
    end
  end

  // No edges until sync and history both hold real pin levels,
  // else a pin already high at reset looks like a rising edge
  assign rise_seen = prime_q[2] ? (sync_q & ~prev_q) : 8'h00;
  assign fall_seen = prime_q[2] ? (~sync_q & prev_q) : 8'h00;

endmodule // pcd_pin_sync

// ===== design/pcd_top.v
// Port pin change detector with classic Wishbone register slave
// Contract
// - Rising-edge enable bit per pin 7..0
// - Falling-edge enable bit per pin 7..0
// - Armed edge sets pin flag and summary
// - Rising enable plus low-to-high sets flag
// - Falling enable plus high-to-low sets flag
// - Flags read/write; software writes zero clears
// - All four registers reset to zero
// - Summary flag is OR of flags
// - Detection runs always; irq needs enable
// - Edge during clearing write wins
// - Enabled edge requests wake only with irq enable; flags first
`timescale 1ns/1ps
`include "pcd_defs.vh"

module pcd_top (
  // Clock and reset
  input wire sys_clk,
  input wire sys_rst,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire wb_err_o,
  // Port pins
  input wire [7:0] port_b_pin,
  // Interrupt and wake
  output wire change_irq,
  output wire wake_request
);

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  reg [7:0] rising_edge_enable_q;
  reg [7:0] rising_edge_enable_d;
  reg [7:0] falling_edge_enable_q;
  reg [7:0] falling_edge_enable_d;
  reg [7:0] pin_change_flags_q;
  reg [7:0] pin_change_flags_d;
  reg change_irq_enable_q;
  reg change_irq_enable_d;
  reg ack_d;
  reg [31:0] rd_data_d;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // Offset 0: rising edge enables, offset 4: falling edge enables
  // Offset 8: change flags, set by hardware, stored on write
  // Offset C: bit 0 interrupt enable, bit 1 summary (read only)
  // Other offsets ack, read zero and ignore writes
  // Only byte lane 0 is written; upper lanes always read zero
  // Offsets must match exactly; no aliasing inside a word

  // ---------------------------------------------------------------
  // Internal nets
  // ---------------------------------------------------------------
  wire [7:0] rise_seen;
  wire [7:0] fall_seen;
  wire [7:0] rise_armed;
  wire [7:0] fall_armed;
  wire [7:0] hit;
  wire change_summary_flag;
  wire req;
  wire req_wr;
  wire req_rd;
  wire wr_rise;
  wire wr_fall;
  wire wr_flag;
  wire wr_ctrl;
  wire [7:0] wr_byte;
  wire [31:0] rd_rise_word;
  wire [31:0] rd_fall_word;
  wire [31:0] rd_flag_word;
  wire [31:0] rd_ctrl_word;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Exact match of a register offset
  function sel_reg;
    input [3:0] adr;
    input [3:0] ofs;
    begin
      sel_reg = (adr == ofs);
    end
  endfunction

  // Zero-extend one register byte to the bus width
  function [31:0] widen;
    input [7:0] val;
    begin
      widen = {24'h000000, val};
    end
  endfunction

  // Control byte: enable in its bit, summary beside it
  function [7:0] ctrl_byte;
    input irq_en;
    input summary;
    reg [7:0] w;
    begin
      w = 8'h00;
      w[`PCD_CTRL_IRQ_EN] = irq_en;
      w[`PCD_CTRL_SUMMARY] = summary;
      ctrl_byte = w;
    end
  endfunction

  // Stored write value, then any new hit forced on top
  function [7:0] flag_next;
    input [7:0] cur;
    input wr_en;
    input [7:0] wdata;
    input [7:0] set;
    reg [7:0] base;
    begin
      base = wr_en ? wdata : cur;
      flag_next = base | set;
    end
  endfunction

  // ---------------------------------------------------------------
  // Edge detection
  // ---------------------------------------------------------------
  pcd_pin_sync u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pin_in(port_b_pin),
    .rise_seen(rise_seen),
    .fall_seen(fall_seen)
  );

  assign rise_armed = rise_seen & rising_edge_enable_q;
  assign fall_armed = fall_seen & falling_edge_enable_q;
  assign hit = rise_armed | fall_armed;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  // One request per ack; a strobe still held after the ack cycle is taken again
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign req_wr = req & wb_we_i & wb_sel_i[0];
  assign req_rd = req & ~wb_we_i;
  assign wr_byte = wb_dat_i[7:0];
  assign wr_rise = req_wr & sel_reg(wb_adr_i, `PCD_OFS_RISE);
  assign wr_fall = req_wr & sel_reg(wb_adr_i, `PCD_OFS_FALL);
  assign wr_flag = req_wr & sel_reg(wb_adr_i, `PCD_OFS_FLAG);
  assign wr_ctrl = req_wr & sel_reg(wb_adr_i, `PCD_OFS_CTRL);
  // Every address answers with ack; unmapped reads return zero
  assign wb_err_o = 1'b0;

  // ---------------------------------------------------------------
  // Enable registers
  // ---------------------------------------------------------------
  // Rising enable write
  always @* begin
    rising_edge_enable_d = rising_edge_enable_q;
    if (wr_rise) begin
      rising_edge_enable_d = wr_byte;
    end
  end

  always @* begin
    falling_edge_enable_d = falling_edge_enable_q;
    if (wr_fall) begin
      falling_edge_enable_d = wr_byte;
    end
  end

  always @* begin
    change_irq_enable_d = change_irq_enable_q;
    if (wr_ctrl) begin
      change_irq_enable_d = wb_dat_i[`PCD_CTRL_IRQ_EN];
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      rising_edge_enable_q <= `PCD_RST_BYTE;
    end else begin
      rising_edge_enable_q <= rising_edge_enable_d;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      falling_edge_enable_q <= `PCD_RST_BYTE;
    end else begin
      falling_edge_enable_q <= falling_edge_enable_d;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      change_irq_enable_q <= 1'b0;
    end else begin
      change_irq_enable_q <= change_irq_enable_d;
    end
  end

  // ---------------------------------------------------------------
  // Change flags
  // ---------------------------------------------------------------
  // Write stores, edge wins
  // Software should write back what it read with those bits cleared;
  // a blind zero write drops edges found since the read
  always @* begin
    pin_change_flags_d = flag_next(pin_change_flags_q, wr_flag, wr_byte,
                                   hit);
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_change_flags_q <= `PCD_RST_BYTE;
    end else begin
      pin_change_flags_q <= pin_change_flags_d;
    end
  end

  // ---------------------------------------------------------------
  // Read words
  // ---------------------------------------------------------------
  assign rd_rise_word = widen(rising_edge_enable_q);
  assign rd_fall_word = widen(falling_edge_enable_q);
  assign rd_flag_word = widen(pin_change_flags_q);
  assign rd_ctrl_word = widen(ctrl_byte(change_irq_enable_q,
                                        change_summary_flag));

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  // Read data stands only in the ack cycle, zero otherwise
  always @* begin
    rd_data_d = 32'h00000000;
    if (req_rd) begin
      case (wb_adr_i)
        `PCD_OFS_RISE: begin
          rd_data_d = rd_rise_word;
        end
        `PCD_OFS_FALL: begin
          rd_data_d = rd_fall_word;
        end
        `PCD_OFS_FLAG: begin
          rd_data_d = rd_flag_word;
        end
        `PCD_OFS_CTRL: begin
          rd_data_d = rd_ctrl_word;
        end
        default: begin
          rd_data_d = 32'h00000000;
        end
      endcase
    end
  end

  // Ack one cycle after the request is taken
  always @* begin
    ack_d = req;
  end

  // Ack flop; drops after one cycle since req needs ack low
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= ack_d;
    end
  end

  // Read data flop, cleared outside the ack cycle
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_dat_o <= rd_data_d;
    end
  end

  // ---------------------------------------------------------------
  // Summary, interrupt and wake
  // ---------------------------------------------------------------
  // OR of flags
  assign change_summary_flag = |pin_change_flags_q;
  // Gated by enable; flags keep setting regardless
  assign change_irq = change_summary_flag & change_irq_enable_q;
  // Wake follows flags, so flags are already updated
  assign wake_request = change_irq;

endmodule // pcd_top

// ===== bench/pcd_pin_src.sv
// Port pin source model driven from the bench
`timescale 1ns/1ps
module pcd_pin_src (input wire sys_clk, input wire [7:0] lvl,
  output reg [7:0] port_b_pin = 8'h00);
  always @(posedge sys_clk) port_b_pin <= lvl;
endmodule // pcd_pin_src

// ===== bench/pcd_top_properties.sv
// Checker on the pin change detector ports
`timescale 1ns/1ps
module pcd_props (input wire sys_clk, sys_rst, wb_stb_i, wb_we_i,
  wb_ack_o, change_irq, wake_request,
  input wire [31:0] wb_dat_o, input wire [7:0] port_b_pin);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_ack_one:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
  a_ack_due:
    assert property (wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("due");
  a_ack_why:
    assert property ($rose(wb_ack_o) |-> $past(wb_stb_i)) else $error("why");
  a_dat_idle:
    assert property (!wb_ack_o |-> !wb_dat_o) else $error("idle");
  a_dat_high:
    assert property (!wb_dat_o[31:8]) else $error("high");
  a_wake_irq:
    assert property (wake_request == change_irq) else $error("wake");
  // Rise needs a write or a pin change three samples back
  a_irq_rise:
    assert property ($rose(change_irq) |-> wb_ack_o && wb_we_i ||
      $past(port_b_pin, 3) != $past(port_b_pin, 4)) else $error("rise");
  a_irq_fall:
    assert property ($fell(change_irq) |-> wb_ack_o && wb_we_i)
      else $error("fall");
  cover property ($rose(change_irq));
  cover property ($fell(change_irq));
  cover property (wb_ack_o && wb_we_i);
endmodule // pcd_props

// ===== bench/test_pcd_top.sv
// Bench for the pin change detector
`timescale 1ns/1ps
module test_pcd_top;
  reg sys_clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  reg [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1;
  reg [7:0] lvl = 8'h00;
  reg [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire [7:0] port_b_pin;
  wire wb_ack_o, change_irq, wake_request, wb_err_o;
  integer error_cnt = 0, check_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  pcd_pin_src src (.*);
  pcd_top dut (.*);
  task chk(input [31:0] s, e);
    check_count += 1;
    error_cnt += (s !== e);
    if (s !== e) $display("mismatch %0t saw %h exp %h", $time, s, e);
  endtask
  // Held until ack is seen; a read must return the given byte v
  task acc(input w, input [3:0] a, input [7:0] v);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, 24'h0, v};
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1) @(posedge sys_clk);
    if (!w) chk(wb_dat_o, v);
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge sys_clk);
  endtask
  task finish_test;
    $display("%0d checks %0d errors", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (2000) @(posedge sys_clk);
    error_cnt += 1;
    finish_test;
  end
  initial begin
    repeat (12) @(posedge sys_clk);
    sys_rst <= 0;
    for (int i = 0; i < 16; i += 2) acc(0, i[3:0], 8'h00);
    chk(wb_err_o, 0);
    acc(1, 4'h0, 8'h0F);
    acc(1, 4'h4, 8'hF0);
    acc(1, 4'hC, 8'h01);
    lvl <= 8'hFF;
    repeat (6) @(posedge sys_clk);
    chk(change_irq, 1);
    acc(0, 4'h8, 8'h0F);
    lvl <= 8'h00;
    repeat (6) @(posedge sys_clk);
    acc(0, 4'h8, 8'hFF);
    acc(0, 4'hC, 8'h03);
    acc(1, 4'h8, 8'h00);
    acc(1, 4'hC, 8'h00);
    lvl <= 8'hFF;
    repeat (6) @(posedge sys_clk);
    chk(change_irq, 0);
    chk(wake_request, 0);
    acc(0, 4'h8, 8'h0F);
    // Clearing write lands one edge before the edge that sets the high nibble
    lvl <= 8'h00;
    repeat (2) @(posedge sys_clk);
    acc(1, 4'h8, 8'h00);
    acc(0, 4'h8, 8'hF0);
    acc(1, 4'hC, 8'h01);
    chk(wake_request, 1);
    // Writes without lane 0 or to a hole change nothing
    wb_sel_i <= 4'h0;
    acc(1, 4'h0, 8'hFF);
    wb_sel_i <= 4'h1;
    acc(0, 4'h0, 8'h0F);
    acc(1, 4'h2, 8'hFF);
    acc(0, 4'h2, 8'h00);
    // Pin 0 armed both ways; flag lands three edges after the pin
    acc(1, 4'h0, 8'h01);
    acc(1, 4'h4, 8'h01);
    acc(1, 4'h8, 8'h00);
    lvl <= 8'h01;
    repeat (4) @(posedge sys_clk);
    chk(change_irq, 0);
    @(posedge sys_clk);
    chk(change_irq, 1);
    acc(1, 4'h8, 8'h00);
    lvl <= 8'h00;
    repeat (6) @(posedge sys_clk);
    acc(0, 4'h8, 8'h01);
    // Mid-run reset clears every register
    chk(change_irq, 1);
    sys_rst <= 1;
    repeat (3) @(posedge sys_clk);
    sys_rst <= 0;
    chk(change_irq, 0);
    for (int i = 0; i < 16; i += 4) acc(0, i[3:0], 8'h00);
    finish_test;
  end
endmodule // test_pcd_top
bind pcd_top pcd_props u_props (.*);
